// *** hw/brwd_bank_regs.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "brwd_defs.svh"
module brwd_bank_regs #(
    parameter int NREGS = 16
) (
    input wire logic sys_clk_i, // Core clock
    input wire logic srst_i, // Sync reset
    input wire logic we_i, // Write strobe
    input wire logic [3:0] idx_i, // Register index
    input wire logic [7:0] wdata_i, // Write data
    output logic [7:0] rdata_o // Read data, combinational select
);
    logic [7:0] mem_q [NREGS];
    genvar g;
    generate
        for (g = 0; g < NREGS; g++) begin : gen_reg
            always_ff @(posedge sys_clk_i) begin
                if (srst_i) begin
                    mem_q[g] <= `BRWD_ZERO_BYTE;
                end else if (we_i && idx_i == 4'(g)) begin
                    mem_q[g] <= wdata_i;
                end
            end
        end
    endgenerate
    assign rdata_o = mem_q[idx_i];
endmodule
`default_nettype wire

// *** hw/brwd_defs.svh ***
`ifndef BRWD_DEFS_SVH
`define BRWD_DEFS_SVH
`define BRWD_PTR_ADDR 8'hFD
`define BRWD_PTR_RESET 8'h00
`define BRWD_BANK_NORMAL 4'h0
`define BRWD_BANK_TIMER 4'hD
`define BRWD_BANK_SYS 4'hF
`define BRWD_SHORT_PREFIX 4'hE
`define BRWD_TMR_CTL0 4'h0
`define BRWD_TMR_CTL1 4'h1
`define BRWD_TMR_CTL2 4'h2
`define BRWD_TMR_RSVD 4'h3
`define BRWD_ZERO_BYTE 8'h00
`endif

// *** hw/brwd_pkg.sv ***
package brwd_pkg;
    typedef enum logic [1:0] {
        BRWD_TGT_FILE = 2'b00,
        BRWD_TGT_BANKD = 2'b01,
        BRWD_TGT_BANKF = 2'b10,
        BRWD_TGT_NONE = 2'b11
    } brwd_target_t;
endpackage

// *** hw/brwd_top.sv ***
// Operation
// - Pointer high nibble selects the 16-byte working group for short addresses.
// - Pointer low nibble selects expanded bank; only 0, F, D exist.
// - Bank selector zero routes all accesses to the ordinary file.
// - Selector 1H..FH replaces lowest 16 locations with the chosen bank.
// - Addresses 0..15 form a window onto banks 0, D and F of 16 registers each.
// - Pointer lives at address 253; pointer 00h maps R0..R3 to ports.
// - Pointer 0Dh maps R0..R2 to timer controls, R3 reserved.
// - Pointer 7Dh: short addresses hit bank D, full 71h hits file.
`timescale 1ns/100ps
`default_nettype none
`include "brwd_defs.svh"
module brwd_top
    import brwd_pkg::*;
(
    input wire logic sys_clk_i, // Core clock, 100 MHz
    input wire logic srst_i, // Sync reset, active high
    input wire logic req_i, // Register access strobe
    input wire logic wr_i, // 1 write, 0 read
    input wire logic short_i, // Address is a 4-bit working reg
    input wire logic [7:0] addr_i, // Full address or short in [3:0]
    input wire logic [7:0] wdata_i, // Write data
    input wire logic [7:0] file_rdata_i, // Read data from bank 0 file
    output logic file_we_o, // Bank 0 file write strobe
    output logic [7:0] file_addr_o, // Bank 0 file address
    output logic [7:0] rdata_o, // Read data, registered
    output logic rvalid_o, // Read data valid pulse
    output logic [7:0] pointer_o, // Current pointer value
    output logic [7:0] timer8_control_o, // Timer8 control
    output logic [7:0] timer_shared_control_o, // Shared timer control
    output logic [7:0] timer16_control_o // Timer16 control
);
    logic [7:0] working_group_pointer_q;
    logic [7:0] eff_addr;
    logic low_window;
    brwd_target_t tgt;
    logic bd_we, bf_we;
    logic [7:0] bd_rdata, bf_rdata, rdata_d;
    logic [7:0] tctl0_q, tctl1_q, tctl2_q;
    logic ptr_hit;
    logic work_form;

    function automatic brwd_target_t brwd_route(input logic [3:0] bank, input logic low);
        brwd_target_t t;
        t = BRWD_TGT_FILE;
        if (!low || bank == `BRWD_BANK_NORMAL) begin
            t = BRWD_TGT_FILE;
        end else if (bank == `BRWD_BANK_TIMER) begin
            t = BRWD_TGT_BANKD;
        end else if (bank == `BRWD_BANK_SYS) begin
            t = BRWD_TGT_BANKF;
        end else begin
            t = BRWD_TGT_NONE;
        end
        return t;
    endfunction

    always_comb begin
        eff_addr = addr_i;
        if (short_i) begin
            eff_addr = {working_group_pointer_q[7:4], addr_i[3:0]};
        end else if (addr_i[7:4] == `BRWD_SHORT_PREFIX) begin
            eff_addr = {working_group_pointer_q[7:4], addr_i[3:0]};
        end
    end

    // full address above 0Fh, other than Ex, bypasses bank swap
    // Ex full form is a working register too, so it must swap like a short one
    assign work_form = short_i || (addr_i[7:4] == `BRWD_SHORT_PREFIX);
    assign low_window = work_form ? (working_group_pointer_q[7:4] == 4'h0)
                                   || (working_group_pointer_q[3:0] != `BRWD_BANK_NORMAL)
                                  : (eff_addr[7:4] == 4'h0);

    assign tgt = brwd_route(working_group_pointer_q[3:0], low_window);

    assign ptr_hit = (tgt == BRWD_TGT_FILE) && (eff_addr == `BRWD_PTR_ADDR);

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            working_group_pointer_q <= `BRWD_PTR_RESET;
        end else if (req_i && wr_i && ptr_hit) begin
            working_group_pointer_q <= wdata_i;
        end
    end

    // ports stay in bank 0 file
    assign file_we_o = req_i && wr_i && (tgt == BRWD_TGT_FILE) && !ptr_hit;
    assign file_addr_o = eff_addr;

    assign bd_we = req_i && wr_i && (tgt == BRWD_TGT_BANKD);
    assign bf_we = req_i && wr_i && (tgt == BRWD_TGT_BANKF);

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            tctl0_q <= `BRWD_ZERO_BYTE;
            tctl1_q <= `BRWD_ZERO_BYTE;
            tctl2_q <= `BRWD_ZERO_BYTE;
        end else if (bd_we) begin
            if (eff_addr[3:0] == `BRWD_TMR_CTL0) begin
                tctl0_q <= wdata_i;
            end else if (eff_addr[3:0] == `BRWD_TMR_CTL1) begin
                tctl1_q <= wdata_i;
            end else if (eff_addr[3:0] == `BRWD_TMR_CTL2) begin
                tctl2_q <= wdata_i;
            end
        end
    end

    // Other bank D slots are plain storage; reserved slot masked on read
    brwd_bank_regs #(.NREGS(16)) u_bank_d (
        .sys_clk_i(sys_clk_i),
        .srst_i(srst_i),
        .we_i(bd_we),
        .idx_i(eff_addr[3:0]),
        .wdata_i(wdata_i),
        .rdata_o(bd_rdata)
    );
    brwd_bank_regs #(.NREGS(16)) u_bank_f (
        .sys_clk_i(sys_clk_i),
        .srst_i(srst_i),
        .we_i(bf_we),
        .idx_i(eff_addr[3:0]),
        .wdata_i(wdata_i),
        .rdata_o(bf_rdata)
    );

    always_comb begin
        rdata_d = `BRWD_ZERO_BYTE;
        case (tgt)
            BRWD_TGT_FILE: begin
                rdata_d = ptr_hit ? working_group_pointer_q : file_rdata_i;
            end
            BRWD_TGT_BANKD: begin
                if (eff_addr[3:0] == `BRWD_TMR_CTL0) begin
                    rdata_d = tctl0_q;
                end else if (eff_addr[3:0] == `BRWD_TMR_CTL1) begin
                    rdata_d = tctl1_q;
                end else if (eff_addr[3:0] == `BRWD_TMR_CTL2) begin
                    rdata_d = tctl2_q;
                end else if (eff_addr[3:0] == `BRWD_TMR_RSVD) begin
                    rdata_d = `BRWD_ZERO_BYTE;
                end else begin
                    rdata_d = bd_rdata;
                end
            end
            BRWD_TGT_BANKF: begin
                rdata_d = bf_rdata;
            end
            default: begin
                rdata_d = `BRWD_ZERO_BYTE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            rdata_o <= `BRWD_ZERO_BYTE;
            rvalid_o <= 1'b0;
        end else begin
            rvalid_o <= req_i && !wr_i;
            if (req_i && !wr_i) begin
                rdata_o <= rdata_d;
            end
        end
    end

    assign pointer_o = working_group_pointer_q;
    assign timer8_control_o = tctl0_q;
    assign timer_shared_control_o = tctl1_q;
    assign timer16_control_o = tctl2_q;

    ptr_write_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        req_i && wr_i && !short_i && addr_i == `BRWD_PTR_ADDR |=> pointer_o == $past(wdata_i))
        else $error("pointer write lost");
    group_select_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        req_i && short_i && tgt == BRWD_TGT_FILE
        |-> file_addr_o == {pointer_o[7:4], addr_i[3:0]})
        else $error("short address not in working group");
    bank0_pass_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        req_i && pointer_o[3:0] == 4'h0 |-> tgt == BRWD_TGT_FILE)
        else $error("bank 0 substituted");
    bank_swap_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        req_i && wr_i && !short_i && addr_i[7:4] == 4'h0 && pointer_o[3:0] != 4'h0
        |-> !file_we_o)
        else $error("low window write reached file");
    timer_write_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        req_i && wr_i && pointer_o == 8'h0D && short_i && addr_i[3:0] == 4'h0
        |=> timer8_control_o == $past(wdata_i))
        else $error("timer8 control not written");
    full_addr_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        req_i && wr_i && pointer_o == 8'h7D && !short_i && addr_i == 8'h71
        |-> file_we_o && file_addr_o == 8'h71)
        else $error("full address swapped");
    unimpl_read_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        req_i && !wr_i && tgt == BRWD_TGT_NONE |=> rvalid_o && rdata_o == 8'h00)
        else $error("unimplemented bank read not zero");
    rsvd_read_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        req_i && !wr_i && tgt == BRWD_TGT_BANKD && eff_addr[3:0] == 4'h3
        |=> rdata_o == 8'h00)
        else $error("reserved slot not zero");
    decode_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        req_i && low_window && pointer_o[3:0] == 4'hF |-> tgt == BRWD_TGT_BANKF)
        else $error("bank F not decoded");
    window_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        req_i && !short_i && addr_i[7:4] != 4'h0 && addr_i[7:4] != 4'hE
        |-> tgt == BRWD_TGT_FILE)
        else $error("upper address swapped");
    work_form_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        req_i && !short_i && addr_i[7:4] == 4'hE && pointer_o[3:0] == 4'hD
        |-> tgt == BRWD_TGT_BANKD)
        else $error("working form not swapped");
endmodule
`default_nettype wire

// *** tb/brwd_file_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module brwd_file_model (
    input wire logic sys_clk_i, // Core clock
    input wire logic we_i, // Write strobe
    input wire logic [7:0] addr_i, // Effective address
    input wire logic [7:0] wdata_i, // Write data
    output logic [7:0] rdata_o // Read data, same cycle
);
    logic [7:0] mem [256];
    // Cleared so that any stray access reads a known value
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'h00;
        end
    end
    always @(posedge sys_clk_i) begin
        if (we_i) begin
            mem[addr_i] <= wdata_i;
        end
    end
    assign rdata_o = mem[addr_i];
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic req = 1'b0;
    logic wr = 1'b0;
    logic sh = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [7:0] frd, faddr, rdata, ptr, t0, t1, t2;
    logic fwe, rvalid;
    int error_cnt = 0;
    int check_count = 0;
    always #5 clk = ~clk;
    brwd_top DUT (.sys_clk_i(clk), .srst_i(srst), .req_i(req), .wr_i(wr), .short_i(sh),
        .addr_i(addr), .wdata_i(wdata), .file_rdata_i(frd), .file_we_o(fwe),
        .file_addr_o(faddr), .rdata_o(rdata), .rvalid_o(rvalid), .pointer_o(ptr),
        .timer8_control_o(t0), .timer_shared_control_o(t1), .timer16_control_o(t2));
    brwd_file_model u_file (.sys_clk_i(clk), .we_i(fwe), .addr_i(faddr), .wdata_i(wdata),
        .rdata_o(frd));
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Request held across exactly one taking edge
    task automatic acc(input logic w, input logic s, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= 1'b1;
        wr <= w;
        sh <= s;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        req <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        acc(1'b0, 1'b1, a, 8'h00);
        chk("rvalid", 8'h01, {7'h00, rvalid});
        q = rdata;
    endtask
    task automatic t_group();
        logic [7:0] q;
        acc(1'b1, 1'b0, 8'hFD, 8'h50);
        chk("pointer", 8'h50, ptr);
        acc(1'b1, 1'b1, 8'h03, 8'hA5);
        chk("file 53", 8'hA5, u_file.mem[8'h53]);
        rd(8'h03, q);
        chk("short 3", 8'hA5, q);
        acc(1'b1, 1'b0, 8'hFD, 8'h00);
        acc(1'b1, 1'b0, 8'h02, 8'h5A);
        rd(8'h02, q);
        chk("port 2", 8'h5A, q);
        $display("test group done");
    endtask
    task automatic t_bankd();
        logic [7:0] q;
        acc(1'b1, 1'b0, 8'hFD, 8'h0D);
        acc(1'b1, 1'b1, 8'h00, 8'h11);
        acc(1'b1, 1'b1, 8'h01, 8'h22);
        acc(1'b1, 1'b1, 8'h02, 8'h33);
        chk("timer8", 8'h11, t0);
        chk("shared", 8'h22, t1);
        chk("timer16", 8'h33, t2);
        chk("file 02", 8'h5A, u_file.mem[8'h02]);
        rd(8'h03, q);
        chk("reserved", 8'h00, q);
        $display("test bank d done");
    endtask
    task automatic t_grp7();
        logic [7:0] q;
        acc(1'b1, 1'b0, 8'hFD, 8'h7D);
        acc(1'b1, 1'b1, 8'h01, 8'h3C);
        chk("shared", 8'h3C, t1);
        acc(1'b1, 1'b0, 8'h71, 8'h66);
        chk("file 71", 8'h66, u_file.mem[8'h71]);
        rd(8'h01, q);
        chk("short 1", 8'h3C, q);
        $display("test group 7 done");
    endtask
    task automatic t_unimpl();
        logic [7:0] q;
        acc(1'b1, 1'b0, 8'hFD, 8'h05);
        acc(1'b1, 1'b1, 8'h02, 8'hFF);
        chk("timer16", 8'h33, t2);
        chk("file 02", 8'h5A, u_file.mem[8'h02]);
        rd(8'h02, q);
        chk("bank 5", 8'h00, q);
        acc(1'b1, 1'b0, 8'hFD, 8'h0F);
        acc(1'b1, 1'b1, 8'h04, 8'hC3);
        rd(8'h04, q);
        chk("bank f", 8'hC3, q);
        chk("file 04", 8'h00, u_file.mem[8'h04]);
        $display("test unimplemented done");
    endtask
    // Ex full form swaps like a short address; plain full addresses above 0Fh do not
    task automatic t_workform();
        acc(1'b1, 1'b0, 8'hFD, 8'h7D);
        acc(1'b1, 1'b0, 8'hE2, 8'h9A);
        chk("timer16", 8'h9A, t2);
        chk("file 72", 8'h00, u_file.mem[8'h72]);
        acc(1'b0, 1'b0, 8'hFD, 8'h00);
        chk("pointer read", 8'h7D, rdata);
        acc(1'b0, 1'b0, 8'h71, 8'h00);
        chk("file read 71", 8'h66, rdata);
        chk("read valid", 8'h01, {7'h00, rvalid});
        $display("test working form done");
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        #1;
        chk("pointer reset", 8'h00, ptr);
        t_group();
        t_bankd();
        t_grp7();
        t_unimpl();
        t_workform();
        close_out();
    end
    // Tests need well under 100 cycles
    initial begin
        #20000;
        error_cnt++;
        close_out();
    end
endmodule
`default_nettype wire
